// *** hdl/nv_access_ctrl.sv ***
// data array access controller with an AHB-Lite register slave
// assumes a single AHB-Lite master, word transfers, on the clk domain
// Functional notes
// - read data lands in the data register the next cycle
// - data register keeps read byte until next read or software write
// - write starts only after exact unlock order then write bit
// - write bit cannot be set while write enable is clear
// - hardware never clears write enable
// - started write completes even if write enable is cleared
// - on completion clear write bit and set write-complete flag
//
// Local design decisions: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ns
`include "nv_access_map.svh"
module nv_access_ctrl
    import nv_access_pkg::*;
#(
    parameter int DEPTH        = 128,
    parameter int AW           = 7,
    parameter int WRITE_CYCLES = `WRITE_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             irq
);

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    logic [AW-1:0] nvAddress;
    logic [7:0]    nvData;
    logic          arraySelect;
    logic          writeEnable;
    logic          writeBusy;
    logic          writeDone;
    logic          maskDone;
    write_state_t  wstate;
    logic [31:0]   wcount;

    // bus address phase capture
    // held for the data phase; hready gates it as the bus rules ask
    logic          dWrite;
    logic          dRead;
    logic [7:0]    dAddr;
    logic          addrPhase;

    // decoded write strobes in the data phase
    logic          wrAddress;
    logic          wrData;
    logic          wrControl;
    logic          wrUnlock;
    logic          wrMask;
    logic          rdStatus;
    logic          anyAccess;
    logic          armed;
    logic          startWrite;
    logic          startRead;
    logic          finishWrite;
    logic [7:0]    arrayRead;
    logic [7:0]    next_hrdata;

    // ---------------------------------------------------------------
    // AHB-Lite address phase
    // ---------------------------------------------------------------
    // an access is taken at the edge that ends its address phase; a write
    // acts on hwdata at the edge that ends its data phase, and a read finds
    // its word in hrdata from that first edge on, so no wait state is needed
    assign addrPhase = hsel && hready && htrans[1];

    // register the access, answered zero-wait in the next cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dWrite <= 1'b0;
            dRead  <= 1'b0;
            dAddr  <= 8'h00;
        end else if (hready) begin
            dWrite <= addrPhase && hwrite;
            dRead  <= addrPhase && !hwrite;
            dAddr  <= haddr[7:0];
        end
    end

    // always ready, always OKAY: no wait states needed
    // kept as flops so every top-level output comes straight from a register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // data-phase strobes; only the low address byte is decoded, so the
    // register set repeats through the rest of the slave's slot
    // unlock and control writes are left out of anyAccess: they are the
    // sequence itself and are judged inside the detector and startWrite
    assign wrAddress = dWrite && dAddr == `NV_ADDRESS_OFS;
    assign wrData    = dWrite && dAddr == `NV_DATA_OFS;
    assign wrControl = dWrite && dAddr == `NV_CONTROL_OFS;
    assign wrUnlock  = dWrite && dAddr == `NV_UNLOCK_OFS;
    assign wrMask    = dWrite && dAddr == `NV_MASK_OFS;
    assign rdStatus  = addrPhase && !hwrite && haddr[7:0] == `NV_STATUS_OFS;
    assign anyAccess = (dWrite || dRead) && !wrUnlock && !wrControl;

    // ---------------------------------------------------------------
    // unlock detector and start conditions
    // ---------------------------------------------------------------
    // a control write that does not start a write also breaks the sequence,
    // so a stale arming can never be used by a later, unrelated write bit
    nv_unlock_detector u_unlock (
        .clk         (clk),
        .rst_b       (rst_b),
        .unlockWrite (wrUnlock),
        .unlockData  (hwdata[7:0]),
        .otherAccess (anyAccess || (wrControl && !startWrite)),
        .consume     (startWrite),
        .armed       (armed)
    );

    // write enable must already be set; same-write enable does not count
    assign startWrite = wrControl && hwdata[`CTL_WRITE_BIT] && writeEnable
                        && armed && !writeBusy && !arraySelect
                        && !hwdata[`CTL_ARRAY_BIT];
    // reads ignored while busy so the cycle is not disturbed
    assign startRead  = wrControl && hwdata[`CTL_READ_BIT] && !writeBusy
                        && !hwdata[`CTL_ARRAY_BIT];
    // last busy cycle: the byte is stored on this edge and the engine moves
    // to its one-cycle done state, which sets the completion flag
    assign finishWrite = (wstate == WR_BUSY) && (wcount == WRITE_CYCLES - 1);

    // ---------------------------------------------------------------
    // address, select and enable bits
    // ---------------------------------------------------------------
    // address is frozen during a write so the target cannot move
    // a moved target mid-cycle would store the byte at the wrong location
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            nvAddress <= '0;
        end else if (wrAddress && !writeBusy) begin
            nvAddress <= hwdata[AW-1:0];
        end
    end

    // enable changes only by software, never by the engine
    // array select only gates new requests; a cycle already running ignores it
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            writeEnable <= 1'b0;
            arraySelect <= 1'b0;
        end else if (wrControl) begin
            writeEnable <= hwdata[`CTL_WRITE_ENABLE_BIT_BIT];
            arraySelect <= hwdata[`CTL_ARRAY_BIT];
        end
    end

    // ---------------------------------------------------------------
    // write engine
    // ---------------------------------------------------------------
    // runs to the end regardless of write enable
    // the count is not tied to write enable or to later bus traffic: once
    // started, a write always lasts WRITE_CYCLES busy cycles plus the done one
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wstate <= WR_IDLE;
            wcount <= 32'h00000000;
        end else begin
            case (wstate)
                WR_IDLE: begin
                    wcount <= 32'h00000000;
                    if (startWrite) begin
                        wstate <= WR_BUSY;
                    end
                end
                WR_BUSY: begin
                    wcount <= wcount + 32'h00000001;
                    if (finishWrite) begin
                        wstate <= WR_DONE;
                    end
                end
                WR_DONE: begin
                    wstate <= WR_IDLE;
                end
                default: begin
                    wstate <= WR_IDLE;
                end
            endcase
        end
    end

    // the done state still counts as busy, so the write bit only reads zero
    // once the completion flag is already set
    assign writeBusy = (wstate != WR_IDLE);

    // ---------------------------------------------------------------
    // array and data register
    // ---------------------------------------------------------------
    // storage stays outside the reset domain; one address serves both ports
    // because reads are never started while a write is busy, when the array is written
    nv_data_array #(
        .DEPTH (DEPTH),
        .AW    (AW)
    ) u_array (
        .clk         (clk),
        .writeStrobe (finishWrite),
        .writeAddr   (nvAddress),
        .writeData   (nvData),
        .readAddr    (nvAddress),
        .readData    (arrayRead)
    );

    // data holds between reads and software writes; the byte is taken at
    // the edge that ends the control write, so a data register read issued
    // right after it, with no gap on the bus, still sees the old byte
    // writes to the data register are dropped while busy: the engine
    // stores this register at the end of the cycle, not a copy of it
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            nvData <= 8'h00;
        end else if (startRead) begin
            nvData <= arrayRead;
        end else if (wrData && !writeBusy) begin
            nvData <= hwdata[7:0];
        end
    end

    // ---------------------------------------------------------------
    // completion flag, mask and interrupt
    // ---------------------------------------------------------------
    // set wins over the clear-on-read in the same cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            writeDone <= 1'b0;
        end else if (wstate == WR_DONE) begin
            writeDone <= 1'b1;
        end else if (rdStatus) begin
            writeDone <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            maskDone <= 1'b0;
        end else if (wrMask) begin
            // interrupt mask, same layout as the status register
            maskDone <= hwdata[`STS_WDONE_BIT];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq <= 1'b0;
        end else begin
            // level interrupt, registered so the output comes from a flop
            irq <= writeDone && maskDone;
        end
    end

    // ---------------------------------------------------------------
    // read data mux, registered into the data phase
    // ---------------------------------------------------------------
    always_comb begin
        next_hrdata = 8'h00;
        case (haddr[7:0])
            `NV_ADDRESS_OFS: next_hrdata = 8'(nvAddress);
            `NV_DATA_OFS:    next_hrdata = nvData;
            `NV_CONTROL_OFS: begin
                next_hrdata[`CTL_WRITE_BIT] = writeBusy;
                next_hrdata[`CTL_WRITE_ENABLE_BIT_BIT]  = writeEnable;
                next_hrdata[`CTL_ARRAY_BIT] = arraySelect;
            end
            `NV_STATUS_OFS:  next_hrdata[`STS_WDONE_BIT] = writeDone;
            `NV_MASK_OFS:    next_hrdata[`STS_WDONE_BIT] = maskDone;
            default:         next_hrdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hrdata <= 32'h00000000;
        end else if (addrPhase && !hwrite) begin
            // loaded only in a read address phase, so the word stands through
            // the data phase and until the next read
            hrdata <= {24'h000000, next_hrdata};
        end
    end

endmodule : nv_access_ctrl

// *** hdl/nv_access_pkg.sv ***
// types shared by the nonvolatile data array controller
// assumes nothing beyond a SystemVerilog-2012 compiler
package nv_access_pkg;

    // unlock detector progress
    typedef enum logic [1:0] {
        UNLOCK_IDLE,
        UNLOCK_GOT_FIRST,
        UNLOCK_ARMED
    } unlock_state_t;

    // write engine progress
    typedef enum logic [1:0] {
        WR_IDLE,
        WR_BUSY,
        WR_DONE
    } write_state_t;

endpackage : nv_access_pkg

// *** hdl/nv_access_map.svh ***
// offsets, field positions, reset values and timing for the nv controller
// assumes inclusion by bare name, once per compile unit
`ifndef NV_ACCESS_MAP_SVH
`define NV_ACCESS_MAP_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define NV_ADDRESS_OFS   8'h00
`define NV_DATA_OFS      8'h04
`define NV_CONTROL_OFS   8'h08
`define NV_UNLOCK_OFS    8'h0C
`define NV_STATUS_OFS    8'h10
`define NV_MASK_OFS      8'h14

// ---------------------------------------------------------------
// control register fields
// ---------------------------------------------------------------
`define CTL_READ_BIT     0
`define CTL_WRITE_BIT    1
`define CTL_WRITE_ENABLE_BIT_BIT     2
`define CTL_ARRAY_BIT    7

// status / mask register fields
`define STS_WDONE_BIT    0

// ---------------------------------------------------------------
// unlock values and reset values
// ---------------------------------------------------------------
`define UNLOCK_FIRST     8'h55
`define UNLOCK_SECOND    8'hAA
`define CONTROL_RESET    8'h00
`define MASK_RESET       8'h00

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define WRITE_TIME_US    4000
`define CLK_MHZ          50
`define WRITE_CYCLES     (`WRITE_TIME_US * `CLK_MHZ)

`endif

// *** hdl/nv_unlock_detector.sv ***
// unlock sequence watcher: arms the write start after 55h then AAh
// assumes one-cycle access strobes from the bus slave on the same clock
`timescale 1ns/1ns
`include "nv_access_map.svh"
module nv_unlock_detector
    import nv_access_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       unlockWrite,
    input  wire logic [7:0] unlockData,
    input  wire logic       otherAccess,
    input  wire logic       consume,
    output logic            armed
);

    unlock_state_t state;

    // ---------------------------------------------------------------
    // sequence tracking
    // ---------------------------------------------------------------
    // any foreign access or wrong value drops back to idle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= UNLOCK_IDLE;
        end else if (consume) begin
            state <= UNLOCK_IDLE;
        end else if (unlockWrite) begin
            if (unlockData == `UNLOCK_FIRST) begin
                state <= UNLOCK_GOT_FIRST;
            end else if (unlockData == `UNLOCK_SECOND && state == UNLOCK_GOT_FIRST) begin
                state <= UNLOCK_ARMED;
            end else begin
                state <= UNLOCK_IDLE;
            end
        end else if (otherAccess) begin
            state <= UNLOCK_IDLE;
        end
    end

    assign armed = (state == UNLOCK_ARMED);

endmodule : nv_unlock_detector

// *** hdl/nv_data_array.sv ***
// byte-wide storage array with a one-cycle write port and a combinational read port
// assumes the controller never reads and writes in the same cycle
`timescale 1ns/1ns
module nv_data_array #(
    parameter int DEPTH = 128,
    parameter int AW    = 7
) (
    input  wire logic          clk,
    input  wire logic          writeStrobe,
    input  wire logic [AW-1:0] writeAddr,
    input  wire logic [7:0]    writeData,
    input  wire logic [AW-1:0] readAddr,
    output logic [7:0]         readData
);

    logic [7:0] cells [DEPTH];

    // ---------------------------------------------------------------
    // storage
    // ---------------------------------------------------------------
    // contents are not reset, like a real nonvolatile array
    always_ff @(posedge clk) begin
        if (writeStrobe) begin
            cells[writeAddr] <= writeData;
        end
    end

    // combinational read; the controller registers the result
    assign readData = cells[readAddr];

endmodule : nv_data_array

// *** dv/nv_access_monitor.sv ***
// port checker for the nv array access controller
// assumes one clock domain and binding onto nv_access_ctrl
`timescale 1ns/1ns
module nv_access_monitor (
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        irq
);
    logic rdTake;
    logic stsRead;
    logic mskTake;
    logic maskBit;

    // address phases taken by the slave
    assign rdTake  = hsel && hready && htrans[1] && !hwrite;
    assign stsRead = rdTake && (haddr[7:0] == 8'h10);

    // shadow of mask bit 0, loaded in the write data phase
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mskTake <= 1'b0;
            maskBit <= 1'b0;
        end else begin
            mskTake <= hsel && hready && htrans[1] && hwrite && (haddr[7:0] == 8'h14);
            if (mskTake) begin
                maskBit <= hwdata[0];
            end
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    // ---------------------------------------------------------------
    // bus and interrupt relations
    // ---------------------------------------------------------------
    ready_high_a: assert property (hreadyout) else $error("wait state inserted");
    resp_okay_a: assert property (!hresp) else $error("error response seen");
    upper_zero_a: assert property (hrdata[31:8] == 24'h0) else $error("upper read bits set");
    unlock_zero_a: assert property (rdTake && haddr[7:0] == 8'h0C |=> hrdata == 32'h0)
        else $error("unlock register read nonzero");
    unmapped_zero_a: assert property (rdTake && haddr[7:0] >= 8'h18 |=> hrdata == 32'h0)
        else $error("unmapped read nonzero");
    data_hold_a: assert property (!rdTake |=> $stable(hrdata))
        else $error("read data moved without a read");
    irq_mask_a: assert property (irq |-> $past(maskBit))
        else $error("interrupt while masked");
    irq_stay_a: assert property ($fell(irq) |-> $past(stsRead, 2) || $past(stsRead, 3)
        || $past(mskTake, 1) || $past(mskTake, 2)) else $error("interrupt dropped by itself");
endmodule : nv_access_monitor

bind nv_access_ctrl nv_access_monitor nv_access_monitor_i (.clk(clk), .rst_b(rst_b),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq));

// *** dv/nv_access_ctrl_tb.sv ***
// self-checking bench for the nv array access controller
// assumes a short write time parameter and a zero-wait bus slave
`timescale 1ns/1ns
module nv_access_ctrl_tb;
    localparam int WCYC = 20;
    logic        clk     = 1'b0;
    logic        rst_b   = 1'b0;
    logic        hsel    = 1'b0;
    logic [31:0] haddr   = 32'h0;
    logic [1:0]  htrans  = 2'h0;
    logic        hwrite  = 1'b0;
    logic [2:0]  hsize   = 3'h2;
    logic [31:0] hwdata  = 32'h0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        irq;
    logic [31:0] rv;
    logic [6:0]  a;
    logic [7:0]  d;
    logic [7:0]  mem [128];
    int          bad_count   = 0;
    int          checks_done = 0;
    int          seed        = 64318;
    int          cyc         = 0;

    // clock, short write time keeps the run brief
    always #10 clk = ~clk;

    nv_access_ctrl #(.WRITE_CYCLES(WCYC)) nv_access_ctrl_i (.clk(clk), .rst_b(rst_b),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .irq(irq));

    // ---------------------------------------------------------------
    // bus and check tasks
    // ---------------------------------------------------------------
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // expected control word: bit7 array select, bit2 enable, bit1 busy, bit0 reads 0
    function automatic logic [31:0] ctlWord(input logic busy, input logic write_enable_bit,
                                            input logic arr);
        return {24'h0, arr, 4'h0, write_enable_bit, busy, 1'b0};
    endfunction : ctlWord

    // one single word transfer; waits on hready, never on a fixed count
    task xfer(input logic [7:0] ad, input logic w, input logic [31:0] wd,
              output logic [31:0] r);
        hsel   <= 1'b1;
        haddr  <= {24'h0, ad};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask : xfer

    task wr(input logic [7:0] ad, input logic [31:0] wd);
        logic [31:0] x;
        xfer(ad, 1'b1, wd, x);
    endtask : wr

    task rd(input logic [7:0] ad, output logic [31:0] r);
        xfer(ad, 1'b0, 32'h0, r);
    endtask : rd

    // mode 0 proper, 1 no enable, 2 swapped unlock, 3 access inside unlock,
    // 4 program array selected together with the write bit
    task startWrite(input logic [6:0] wa, input logic [7:0] wd, input int mode);
        wr(8'h00, {25'h0, wa});
        wr(8'h04, {24'h0, wd});
        wr(8'h08, (mode == 1) ? 32'h0 : 32'h4);
        wr(8'h0C, (mode == 2) ? 32'hAA : 32'h55);
        if (mode == 3) begin
            rd(8'h00, rv);
        end
        wr(8'h0C, (mode == 2) ? 32'h55 : 32'hAA);
        wr(8'h08, (mode == 1) ? 32'h2 : (mode == 4) ? 32'h86 : 32'h6);
    endtask : startWrite

    // poll the write bit, bounded
    task waitDone;
        int n;
        n = 0;
        do begin
            rd(8'h08, rv);
            n++;
        end while (rv[1] !== 1'b0 && n < 100);
    endtask : waitDone

    task readByte(input logic [6:0] ra, output logic [31:0] r);
        wr(8'h00, {25'h0, ra});
        wr(8'h08, 32'h1);
        rd(8'h04, r);
    endtask : readByte

    task wrap_up;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : wrap_up

    // hang guard, far above the few hundred cycles the tests take
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            $display("[ERR] %0t run timed out", $time);
            wrap_up;
        end
    end

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            rd(8'(i * 4), rv);
            chk(rv, 32'h0);
        end
        $display("test reset values done");
        // random bytes, both ends of the address range first
        for (int i = 0; i < 4; i++) begin
            a = (i == 0) ? 7'h7F : (i == 1) ? 7'h00 : 7'($random(seed));
            d = 8'($random(seed));
            startWrite(a, d, 0);
            mem[a] = d;
            rd(8'h08, rv);
            chk(rv, ctlWord(1'b1, 1'b1, 1'b0));
            waitDone;
            chk(rv, ctlWord(1'b0, 1'b1, 1'b0));
            repeat (10) @(posedge clk);
            chk({31'h0, irq}, 32'h0);
            rd(8'h10, rv);
            chk(rv, 32'h1);
            rd(8'h10, rv);
            chk(rv, 32'h0);
            readByte(a, rv);
            chk(rv, {24'h0, d});
        end
        $display("test write and read back done");
        for (int m = 1; m < 5; m++) begin
            startWrite(7'h7F, ~mem[127], m);
            rd(8'h08, rv);
            chk(rv, ctlWord(1'b0, m != 1, m == 4));
            readByte(7'h7F, rv);
            chk(rv, {24'h0, mem[127]});
        end
        $display("test refused sequences done");
        wr(8'h14, 32'h1);
        a = 7'($random(seed));
        d = 8'($random(seed));
        startWrite(a, d, 0);
        wr(8'h08, 32'h0);
        wr(8'h00, {25'h0, a ^ 7'h01});
        wr(8'h04, {24'h0, ~d});
        wr(8'h08, 32'h1);
        waitDone;
        chk(rv, ctlWord(1'b0, 1'b0, 1'b0));
        for (int n = 0; n < 10 && irq !== 1'b1; n++) @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        rd(8'h10, rv);
        chk(rv, 32'h1);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        readByte(a, rv);
        chk(rv, {24'h0, d});
        wr(8'h00, {25'h0, ~a});
        repeat (4) @(posedge clk);
        rd(8'h04, rv);
        chk(rv, {24'h0, d});
        $display("test busy cycle and interrupt done");
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        rd(8'h14, rv);
        chk(rv, 32'h0);
        $display("test second reset done");
        wrap_up;
    end
endmodule : nv_access_ctrl_tb
